/* design/btlp_top.sv */
// Design decisions made here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "btlp_consts.svh"

module btlp_top
(
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire btlp_pkg::btlp_wb_req_t wb_req,
  output      btlp_pkg::btlp_wb_rsp_t wb_rsp,
  input  wire logic                  addr_strobe_n,
  input  wire logic                  dtack_n,
  output      logic                  bus_error_n,
  input  wire logic                  stop_done,
  input  wire logic [15:0]           internal_interrupt_request,
  output      logic                  core_clk_en,
  output      logic                  core_reset,
  output      logic                  ext_reset_drive,
  output      logic                  clock_output_enable,
  output      logic                  standby
);
  import btlp_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  btlp_wb_rsp_t wb_rsp_q;
  btlp_scr_t    scr_q;
  logic [15:0]  imr_q;
  logic         as_s1_q;
  logic         as_s2_q;
  logic         as_prev_q;
  logic         dt_s1_q;
  logic         dt_s2_q;
  logic [3:0]   to_pre_q;
  logic [9:0]   to_cnt_q;
  logic         counting_q;
  logic         timed_out_q;
  logic         bus_error_n_q;
  btlp_state_t  state_q;
  logic [4:0]   rst_cnt_q;
  logic [5:0]   rst_len_q;
  logic         core_reset_q;
  logic [3:0]   div_pre_q;
  logic         div_half_q;
  logic [4:0]   div_cnt_q;
  logic         core_clk_en_q;
  logic         clock_output_enable_q;
  logic         ext_reset_drive_q;
  logic         standby_q;
  logic         wb_hit;
  logic         wb_wr;
  logic         as_rise;
  logic         to_tick;
  logic         to_expire;
  logic [10:0]  to_span;
  logic [9:0]   to_load;
  logic         wake;
  logic         p_tick;
  logic         h_tick;
  logic         d_tick;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------

  // A request is answered one cycle after it is seen; the write lands on
  // the edge where the master samples ack, so it happens exactly once.
  assign wb_hit = wb_req.cyc && wb_req.stb;
  assign wb_wr  = wb_hit && wb_req.we && wb_rsp_q.ack;

  // Ack and read data; unmapped offsets read as zero and are still acked.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wb_rsp_q <= '0;
    end
    else
    begin
      wb_rsp_q.ack <= wb_hit && !wb_rsp_q.ack;
      case (wb_req.adr)
        `BTLP_ADR_SCR:  wb_rsp_q.dat <= 32'(scr_q);
        `BTLP_ADR_IMR:  wb_rsp_q.dat <= 32'(imr_q);
        `BTLP_ADR_STAT: wb_rsp_q.dat <= 32'({core_reset_q, standby_q, counting_q});
        default:        wb_rsp_q.dat <= 32'h00000000;
      endcase
    end
  end

  // System control register. The timeout flag is cleared by writing one,
  // and a timeout in the same cycle wins over that clear.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      scr_q.timeout_monitor_enable <= `BTLP_TIMEOUT_MONITOR_ENABLE_RST;
      scr_q.timeout_count_select   <= `BTLP_TIMEOUT_COUNT_SELECT_RST;
      scr_q.bus_timeout_flag       <= 1'h0;
      {scr_q.wake_recovery_select, scr_q.divider_prescale_select,
       scr_q.standby_enable, scr_q.core_clock_divider} <= `BTLP_LOW_RST;
    end
    else
    begin
      if (wb_wr && wb_req.adr == `BTLP_ADR_SCR && wb_req.sel[0])
      begin
        // Low byte: recovery, prescale, enable, divider.
        {scr_q.wake_recovery_select, scr_q.divider_prescale_select,
         scr_q.standby_enable, scr_q.core_clock_divider}
          <= wb_req.dat[`BTLP_LOW_MSB:`BTLP_LOW_LSB];
      end
      if (wb_wr && wb_req.adr == `BTLP_ADR_SCR && wb_req.sel[1])
      begin
        {scr_q.timeout_count_select, scr_q.timeout_monitor_enable}
          <= wb_req.dat[`BTLP_WD_MSB:`BTLP_WD_LSB];
      end
      if (to_expire)
      begin
        scr_q.bus_timeout_flag <= 1'h1;
      end
      else if (wb_wr && wb_req.adr == `BTLP_ADR_SCR && wb_req.sel[1]
               && wb_req.dat[`BTLP_HWT_BIT])
      begin
        scr_q.bus_timeout_flag <= 1'h0;
      end
    end
  end

  // Interrupt mask: a one lets that source wake the core.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      imr_q <= `BTLP_IMR_RST;
    end
    else if (wb_wr && wb_req.adr == `BTLP_ADR_IMR && (|wb_req.sel[1:0]))
    begin
      imr_q <= wb_req.dat[`BTLP_IMR_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // Bus timeout monitor
  // ----------------------------------------------------------------

  // Pin synchronisers; only the second stage is read by logic.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      as_s1_q   <= 1'h0;
      as_s2_q   <= 1'h0;
      as_prev_q <= 1'h0;
      dt_s1_q   <= 1'h0;
      dt_s2_q   <= 1'h0;
    end
    else
    begin
      as_s1_q   <= !addr_strobe_n;
      as_s2_q   <= as_s1_q;
      as_prev_q <= as_s2_q;
      dt_s1_q   <= !dtack_n;
      dt_s2_q   <= dt_s1_q;
    end
  end

  assign as_rise   = as_s2_q && !as_prev_q;
  // The prescaler runs free, so the first tick of a cycle may come early;
  // this is why successive timeouts differ by up to 15 clocks.
  assign to_tick   = (to_pre_q == `BTLP_PRE_LAST);
  // The enable is looked at here too, so a monitor switched off mid-cycle
  // cannot still fire on the one edge before counting stops.
  assign to_expire = counting_q && as_s2_q && to_tick && (to_cnt_q == 10'h000)
                     && scr_q.timeout_monitor_enable;
  assign to_span   = `BTLP_TO_BASE << scr_q.timeout_count_select;
  assign to_load   = 10'(to_span - `BTLP_TO_ONE);

  // Free running 4-bit prescaler.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      to_pre_q <= 4'h0;
    end
    else
    begin
      to_pre_q <= to_pre_q + 4'h1;
    end
  end

  // Down counter: reloads at each strobe, stops on negation or acknowledge.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      to_cnt_q   <= 10'h000;
      counting_q <= 1'h0;
    end
    else if (as_rise)
    begin
      to_cnt_q   <= to_load;
      counting_q <= scr_q.timeout_monitor_enable;
    end
    else if (!as_s2_q || dt_s2_q || !scr_q.timeout_monitor_enable || to_expire)
    begin
      counting_q <= 1'h0;
    end
    else if (counting_q && to_tick)
    begin
      to_cnt_q <= to_cnt_q - 10'h001;
    end
  end

  // Bus error is held from expiry until the strobe negates.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      timed_out_q   <= 1'h0;
      bus_error_n_q <= 1'h1;
    end
    else
    begin
      timed_out_q   <= as_s2_q && (timed_out_q || to_expire);
      bus_error_n_q <= !(as_s2_q && (timed_out_q || to_expire));
    end
  end

  // ----------------------------------------------------------------
  // Standby sequencer
  // ----------------------------------------------------------------

  assign wake = |(internal_interrupt_request & imr_q);

  // Only the core is touched here; no register of this block is reset by
  // a wake, so peripheral state survives either recovery.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_q   <= BTLP_RUN;
      rst_cnt_q <= 5'h00;
    end
    else
    begin
      case (state_q)
        BTLP_RUN:
        begin
          if (stop_done && scr_q.standby_enable)
          begin
            state_q <= BTLP_STANDBY;
          end
        end
        BTLP_STANDBY:
        begin
          if (wake && scr_q.wake_recovery_select)
          begin
            state_q   <= BTLP_CORE_RST;
            rst_cnt_q <= `BTLP_CORE_RST_CYC;
          end
          else if (wake)
          begin
            state_q <= BTLP_RUN;
          end
        end
        BTLP_CORE_RST:
        begin
          rst_cnt_q <= rst_cnt_q - 5'h01;
          if (rst_cnt_q == 5'h01)
          begin
            state_q <= BTLP_RUN;
          end
        end
        default:
        begin
          state_q <= BTLP_RUN;
        end
      endcase
    end
  end

  // Core reset, standby indication and pin controls.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      core_reset_q          <= 1'h0;
      standby_q             <= 1'h0;
      ext_reset_drive_q     <= 1'h0;
      clock_output_enable_q <= 1'h1;
    end
    else
    begin
      core_reset_q          <= (state_q == BTLP_STANDBY && wake && scr_q.wake_recovery_select)
                               || (state_q == BTLP_CORE_RST && rst_cnt_q != 5'h01);
      standby_q             <= (state_q == BTLP_STANDBY);
      ext_reset_drive_q     <= 1'h0;
      clock_output_enable_q <= 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // Core clock divider
  // ----------------------------------------------------------------

  // Optional divide by 16, then by 2, then by divider value plus one.
  assign p_tick = !scr_q.divider_prescale_select || (div_pre_q == `BTLP_PRE_LAST);
  assign h_tick = p_tick && div_half_q;
  assign d_tick = h_tick && (div_cnt_q == 5'h00);

  // The chain restarts on every standby entry so the first slow edge
  // comes a full period later; the core sees an enable, not a new clock.
  always_ff @(posedge sys_clk)
  begin
    if (reset || state_q != BTLP_STANDBY)
    begin
      div_pre_q  <= 4'h0;
      div_half_q <= 1'h0;
      div_cnt_q  <= scr_q.core_clock_divider;
    end
    else
    begin
      div_pre_q <= div_pre_q + 4'h1;
      if (p_tick)
      begin
        div_half_q <= !div_half_q;
      end
      if (h_tick)
      begin
        div_cnt_q <= (div_cnt_q == 5'h00) ? scr_q.core_clock_divider : div_cnt_q - 5'h01;
      end
    end
  end

  // Full rate enable outside standby, one pulse per ratio inside it.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      core_clk_en_q <= 1'h1;
    end
    else
    begin
      core_clk_en_q <= (state_q != BTLP_STANDBY) || d_tick;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_rsp              = wb_rsp_q;
  assign bus_error_n         = bus_error_n_q;
  assign core_clk_en         = core_clk_en_q;
  assign core_reset          = core_reset_q;
  assign ext_reset_drive     = ext_reset_drive_q;
  assign clock_output_enable = clock_output_enable_q;
  assign standby             = standby_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  chk_berr_needs_as: assert property (
    !bus_error_n_q |-> $past(as_s2_q))
    else $error("Bus error asserted without address strobe.");

  chk_flag_on_timeout: assert property (
    $rose(timed_out_q) |-> scr_q.bus_timeout_flag && !bus_error_n_q)
    else $error("Timeout did not set flag and bus error.");

  chk_reload_strobe: assert property (
    as_rise |=> to_cnt_q == $past(to_load))
    else $error("Counter not reloaded on strobe assertion.");

  chk_disabled_quiet: assert property (
    (!scr_q.timeout_monitor_enable && !timed_out_q) |=> !timed_out_q)
    else $error("Timeout raised while monitor disabled.");

  chk_standby_entry: assert property (
    (state_q == BTLP_RUN && !(stop_done && scr_q.standby_enable))
      |=> state_q != BTLP_STANDBY)
    else $error("Standby entered without enable and stop.");

  chk_masked_no_wake: assert property (
    (state_q == BTLP_STANDBY && !wake) |=> state_q == BTLP_STANDBY)
    else $error("Standby left without unmasked interrupt.");

  chk_unmasked_wakes: assert property (
    (state_q == BTLP_STANDBY && wake) |=> state_q != BTLP_STANDBY ##1 core_clk_en_q)
    else $error("Unmasked interrupt did not end standby.");

  // Helper: cycles the current core reset pulse has stood so far. A counter
  // keeps the length check cheap; a long repetition would be unrolled.
  always_ff @(posedge sys_clk)
  begin
    if (reset || !core_reset_q)
    begin
      rst_len_q <= 6'h00;
    end
    else
    begin
      rst_len_q <= rst_len_q + 6'h01;
    end
  end

  chk_core_reset_len: assert property (
    $fell(core_reset_q) |-> (rst_len_q >= `BTLP_RST_LEN_MIN)
                            && (rst_len_q <= `BTLP_RST_LEN_MAX))
    else $error("Core reset length outside 16 to 32 clocks.");

  chk_core_reset_cap: assert property (
    core_reset_q |-> rst_len_q < `BTLP_RST_LEN_MAX)
    else $error("Core reset held longer than 32 clocks.");

  chk_no_pin_reset: assert property (
    core_reset_q |-> !ext_reset_drive_q && clock_output_enable_q)
    else $error("External reset driven or clock pin stopped.");
endmodule

/* pkg/btlp_consts.svh */
`ifndef BTLP_CONSTS_SVH
`define BTLP_CONSTS_SVH
// Contract
// - With the monitor enabled, count clocks from each address strobe until it negates. The code also stops the count on acknowledge.
// - On count expiry with strobe still asserted, set timeout flag, hold bus error.
// - Monitor is a 10-bit down counter behind a 4-bit prescaler, 16-clock resolution.
// - Monitor enable bit: 0 disables, 1 enables; resets to 1.
// - Count select codes 000 to 111 pick 128 up to 16K clocks, doubling.
// - Count select resets to all ones, the 16K clock timeout.
// - Standby is entered only after standby enable is set and STOP completes.
// - In standby the core idles on a divided clock; everything else runs full speed.
// - Any of 16 unmasked pending internal interrupts ends standby.
// - A masked interrupt source never ends standby.
// - Recovery select clear: wake restores full clock, keeps all state.
// - Clock output pin keeps running at full rate through standby.
// - Recovery select set: wake applies a 16 to 32 clock core reset.
// - The external reset pin is never driven by the wake core reset.
// - Destructive wake keeps all peripheral and register state; only core state lost.
// - Low byte 20h is divide by 2 standby; FFh adds recovery, max divide; A0h.
// - Standby core clock is system clock over 2 over divider value plus one.
// - Prescale select puts a divide by 16 ahead, ratios 32 to 1024.

// Register byte offsets.
`define BTLP_ADR_SCR      8'h00
`define BTLP_ADR_IMR      8'h04
`define BTLP_ADR_STAT     8'h08
// Field positions in write data.
`define BTLP_LOW_MSB      7
`define BTLP_LOW_LSB      0
`define BTLP_WD_MSB       11
`define BTLP_WD_LSB       8
`define BTLP_HWT_BIT      12
`define BTLP_IMR_MSB      15
// Reset values.
`define BTLP_TIMEOUT_MONITOR_ENABLE_RST    1'h1
`define BTLP_TIMEOUT_COUNT_SELECT_RST    3'h7
`define BTLP_LOW_RST      8'h00
`define BTLP_IMR_RST      16'h0000
// Timing counts.
`define BTLP_TO_BASE      11'h008
`define BTLP_TO_ONE       11'h001
`define BTLP_PRE_LAST     4'hF
`define BTLP_CORE_RST_CYC 5'h18
`define BTLP_RST_LEN_MIN  6'h10
`define BTLP_RST_LEN_MAX  6'h20
`endif

/* pkg/btlp_pkg.sv */
package btlp_pkg;
  // Wishbone request from the master.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } btlp_wb_req_t;

  // Wishbone answer to the master.
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } btlp_wb_rsp_t;

  // System control register layout, bit 12 down to bit 0.
  typedef struct packed {
    logic       bus_timeout_flag;
    logic [2:0] timeout_count_select;
    logic       timeout_monitor_enable;
    logic       wake_recovery_select;
    logic       divider_prescale_select;
    logic       standby_enable;
    logic [4:0] core_clock_divider;
  } btlp_scr_t;

  // Standby sequencer states, Gray coded along run, standby, core reset.
  typedef enum logic [1:0] {
    BTLP_RUN      = 2'h0,
    BTLP_STANDBY  = 2'h1,
    BTLP_CORE_RST = 2'h3
  } btlp_state_t;
endpackage

/* tb/btlp_partner.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bus master and core model
// ----------------------------------------------------------------
module btlp_partner
(
  input  wire logic        sys_clk,
  output      logic        addr_strobe_n,
  output      logic        dtack_n,
  output      logic        stop_done,
  output      logic [15:0] irq
);
  // Released bus pins rest at their pull-up level.
  initial
  begin
    addr_strobe_n = 1'b1;
    dtack_n = 1'b1;
    stop_done = 1'b0;
    irq = 16'h0000;
  end

  // Strobe and acknowledge change just after a rising edge.
  task automatic pins(input logic as_n, input logic dt_n);
    @(posedge sys_clk);
    addr_strobe_n <= as_n;
    dtack_n <= dt_n;
  endtask

  // The core reports a finished STOP with a one-cycle pulse.
  task automatic stop_pulse();
    @(posedge sys_clk);
    stop_done <= 1'b1;
    @(posedge sys_clk);
    stop_done <= 1'b0;
  endtask

  // External wake events arrive only as internal requests, never as a pin of their own.
  task automatic set_irq(input logic [15:0] v);
    @(posedge sys_clk);
    irq <= v;
  endtask
endmodule

/* tb/tb_bus_timeout_and_low_power.sv */
`timescale 1ns/1ps
module tb_bus_timeout_and_low_power;
  import btlp_pkg::*;
  logic         sys_clk;
  logic         reset;
  btlp_wb_req_t wb_req;
  btlp_wb_rsp_t wb_rsp;
  logic         addr_strobe_n;
  logic         dtack_n;
  logic         bus_error_n;
  logic         stop_done;
  logic [15:0]  irq;
  logic         core_clk_en;
  logic         core_reset;
  logic         ext_reset_drive;
  logic         clock_output_enable;
  logic         standby;
  int           fails;
  int           n_compared;

  // ----------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------
  // The crystal rate never changes, so only the internal divider slows the core.
  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;

  btlp_top i_dut
  (
    .sys_clk                    (sys_clk),
    .reset                      (reset),
    .wb_req                     (wb_req),
    .wb_rsp                     (wb_rsp),
    .addr_strobe_n              (addr_strobe_n),
    .dtack_n                    (dtack_n),
    .bus_error_n                (bus_error_n),
    .stop_done                  (stop_done),
    .internal_interrupt_request (irq),
    .core_clk_en                (core_clk_en),
    .core_reset                 (core_reset),
    .ext_reset_drive            (ext_reset_drive),
    .clock_output_enable        (clock_output_enable),
    .standby                    (standby)
  );

  btlp_partner i_partner
  (
    .sys_clk       (sys_clk),
    .addr_strobe_n (addr_strobe_n),
    .dtack_n       (dtack_n),
    .stop_done     (stop_done),
    .irq           (irq)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Every comparison is counted; a mismatch is printed at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Classic cycle: hold the request until ack is sampled, then release it.
  // No answer time is assumed; only the watchdog ends a wait that hangs.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                    input logic [3:0] sel, output logic [31:0] rdat);
    @(posedge sys_clk);
    wb_req <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:sel, dat:wdat};
    do
    begin
      @(posedge sys_clk);
    end
    while (wb_rsp.ack !== 1'b1);
    rdat = wb_rsp.dat;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
  endtask

  // Watchdog fields in bits 12:8, with a one in the flag position to clear it.
  function automatic logic [31:0] wd_word(input logic [2:0] code, input logic en);
    return {19'h0, 1'b1, code, en, 8'h00};
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, an unmapped read, and a STOP while standby is disabled.
  task automatic t_reset();
    logic [31:0] rd;
    wb(1'b0, 8'h00, 32'h0, 4'hF, rd);
    chk(rd, 32'h00000F00);
    wb(1'b0, 8'h0C, 32'h0, 4'hF, rd);
    chk(rd, 32'h0);
    chk({26'h0, bus_error_n, core_clk_en, core_reset, ext_reset_drive,
         clock_output_enable, standby}, 32'h32);
    i_partner.stop_pulse();
    wait_n(4);
    chk({31'h0, standby}, 32'h0);
  endtask

  // A strobe left without acknowledge must raise the bus error after the chosen count.
  task automatic t_timeout(input logic [2:0] code);
    logic [31:0] rd;
    int          n;
    int          lim;
    lim = 128 << code;
    n = 0;
    wb(1'b1, 8'h00, wd_word(code, 1'b1), 4'h2, rd);
    i_partner.pins(1'b0, 1'b1);
    while (bus_error_n === 1'b1 && n < 20000)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, n >= lim - 16 && n <= lim + 24}, 32'h1);
    wait_n(20);
    chk({31'h0, bus_error_n}, 32'h0);
    i_partner.pins(1'b1, 1'b1);
    wait_n(6);
    chk({31'h0, bus_error_n}, 32'h1);
    wb(1'b0, 8'h00, 32'h0, 4'hF, rd);
    chk({31'h0, rd[12]}, 32'h1);
  endtask

  // A new strobe restarts the count from its own start; then the flag is cleared.
  task automatic t_reload();
    logic [31:0] rd;
    int          n;
    n = 0;
    wb(1'b1, 8'h00, wd_word(3'h0, 1'b1), 4'h2, rd);
    i_partner.pins(1'b0, 1'b1);
    wait_n(50);
    wb(1'b0, 8'h08, 32'h0, 4'hF, rd);
    chk(rd, 32'h1);
    wait_n(47);
    i_partner.pins(1'b1, 1'b1);
    wait_n(3);
    i_partner.pins(1'b0, 1'b1);
    while (bus_error_n === 1'b1 && n < 1000)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, n >= 112 && n <= 152}, 32'h1);
    i_partner.pins(1'b1, 1'b1);
    wait_n(6);
    wb(1'b1, 8'h00, wd_word(3'h0, 1'b1), 4'h2, rd);
    wb(1'b0, 8'h00, 32'h0, 4'hF, rd);
    chk({31'h0, rd[12]}, 32'h0);
  endtask

  // A long strobe that must not produce a bus error.
  task automatic quiet_cycle(input logic en, input logic dt_n);
    logic [31:0] rd;
    logic        seen;
    seen = 1'b0;
    wb(1'b1, 8'h00, wd_word(3'h0, en), 4'h2, rd);
    i_partner.pins(1'b0, 1'b1);
    wait_n(20);
    i_partner.pins(1'b0, dt_n);
    repeat (300)
    begin
      @(posedge sys_clk);
      seen = seen | ~bus_error_n;
    end
    i_partner.pins(1'b1, 1'b1);
    wait_n(4);
    chk({31'h0, seen}, 32'h0);
  endtask

  // Enter standby, check the core clock rate, ignore a masked source, wake on an open one.
  task automatic t_standby(input logic [7:0] low, input int ratio, input logic rec);
    logic [31:0] rd;
    int          pulses;
    int          rst;
    int          ext;
    pulses = 0;
    rst = 0;
    ext = 0;
    wb(1'b1, 8'h00, {24'h0, low}, 4'h1, rd);
    wb(1'b1, 8'h04, 32'h2, 4'h3, rd);
    i_partner.stop_pulse();
    wait_n(4);
    chk({31'h0, standby}, 32'h1);
    wb(1'b0, 8'h08, 32'h0, 4'hF, rd);
    chk(rd, 32'h2);
    repeat (2 * ratio)
    begin
      @(posedge sys_clk);
      pulses += core_clk_en;
    end
    chk(pulses, 32'h2);
    chk({31'h0, clock_output_enable}, 32'h1);
    i_partner.set_irq(16'h0001);
    wait_n(10);
    chk({31'h0, standby}, 32'h1);
    i_partner.set_irq(16'h0003);
    repeat (60)
    begin
      @(posedge sys_clk);
      rst += core_reset;
      ext += ext_reset_drive;
    end
    chk({31'h0, standby}, 32'h0);
    chk({31'h0, rec ? (rst >= 16 && rst <= 32) : (rst == 0)}, 32'h1);
    chk(ext, 32'h0);
    chk({31'h0, core_clk_en}, 32'h1);
    wb(1'b0, 8'h04, 32'h0, 4'hF, rd);
    chk(rd, 32'h2);
    wb(1'b0, 8'h00, 32'h0, 4'hF, rd);
    chk({24'h0, rd[7:0]}, {24'h0, low});
    i_partner.set_irq(16'h0000);
  endtask

  // ----------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Reset is held for six cycles, then the scenarios run in order.
  initial
  begin
    wb_req = '0;
    reset = 1'b1;
    fails = 0;
    n_compared = 0;
    wait_n(6);
    reset <= 1'b0;
    t_reset();
    for (int c = 0; c < 8; c++)
      t_timeout(3'(c));
    t_reload();
    quiet_cycle(1'b0, 1'b1);
    quiet_cycle(1'b1, 1'b0);
    t_standby(8'h20, 2, 1'b0);
    t_standby(8'h23, 8, 1'b0);
    t_standby(8'h61, 64, 1'b0);
    t_standby(8'hFF, 1024, 1'b1);
    t_standby(8'hA0, 2, 1'b1);
    tally_and_finish();
  end

  // The full run needs about 37000 cycles; 60000 cycles means a hang.
  initial
  begin
    #1200000;
    fails++;
    tally_and_finish();
  end
endmodule
